//--- rtl/synth_config_registers.sv
// Configuration register bank of a programmable fractional-N synthesizer.
// Assumes the serial front end presents byte reads and writes on CLK_SYS.
module synth_config_registers
   import synth_cfg_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // Register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic [DATA_W-1:0] REG_WDATA,
   output logic [DATA_W-1:0] REG_RDATA,
   output logic REG_HIT,
   // Decoded configuration
   output logic [9:0] OSC_MARGIN_OFFSET,
   output logic DIFF_BUFFER_POWERDOWN,
   output logic [1:0] OUT_FORMAT,
   output logic [8:0] OUT_DIVIDER,
   output logic OUT_DIVIDER_VALID,
   output logic [11:0] PLL_INT_N_DIVIDER,
   output logic [21:0] PLL_FRAC_NUMERATOR,
   output logic [21:0] PLL_FRAC_DENOMINATOR
);
   // Write selects, one per mapped offset
   logic sel_osc_hi;
   logic sel_osc_lo;
   logic sel_drv_ctrl;
   logic sel_div_hi;
   logic sel_div_lo;
   logic sel_nint_hi;
   logic sel_nint_lo;
   logic sel_num_b2;
   logic sel_num_b1;
   logic sel_num_b0;
   logic sel_den_b2;
   logic sel_den_b1;
   logic sel_den_b0;
   // Stored bytes as seen by the read mux and the field assembly
   logic [7:0] osc_hi_byte;
   logic [7:0] osc_lo_byte;
   logic [7:0] drv_ctrl_byte;
   logic [7:0] div_hi_byte;
   logic [7:0] div_lo_byte;
   logic [7:0] nint_hi_byte;
   logic [7:0] nint_lo_byte;
   logic [7:0] num_b2_byte;
   logic [7:0] num_b1_byte;
   logic [7:0] num_b0_byte;
   logic [7:0] den_b2_byte;
   logic [7:0] den_b1_byte;
   logic [7:0] den_b0_byte;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic hit_d;

   // Address decode; a write strobe reaches only the selected byte
   assign sel_osc_hi = (REG_ADDR == OFS_OSC_MARGIN_HI);
   assign sel_osc_lo = (REG_ADDR == OFS_OSC_MARGIN_LO);
   assign sel_drv_ctrl = (REG_ADDR == OFS_OUT_DRV_CTRL);
   assign sel_div_hi = (REG_ADDR == OFS_OUT_DIV_HI);
   assign sel_div_lo = (REG_ADDR == OFS_OUT_DIV_LO);
   assign sel_nint_hi = (REG_ADDR == OFS_PLL_INT_HI);
   assign sel_nint_lo = (REG_ADDR == OFS_PLL_INT_LO);
   assign sel_num_b2 = (REG_ADDR == OFS_FRAC_NUM_B2);
   assign sel_num_b1 = (REG_ADDR == OFS_FRAC_NUM_B1);
   assign sel_num_b0 = (REG_ADDR == OFS_FRAC_NUM_B0);
   assign sel_den_b2 = (REG_ADDR == OFS_FRAC_DEN_B2);
   assign sel_den_b1 = (REG_ADDR == OFS_FRAC_DEN_B1);
   assign sel_den_b0 = (REG_ADDR == OFS_FRAC_DEN_B0);

   // Byte registers; masked bits never load, so writes leave them at zero
   cfg_byte_reg #(
      .RESET_VAL(RST_OSC_MARGIN_HI),
      .STORE_MASK(MASK_OSC_MARGIN_HI)
   ) u_osc_hi (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_osc_hi),
      .wr_data(REG_WDATA),
      .value(osc_hi_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_OSC_MARGIN_LO),
      .STORE_MASK(MASK_FULL)
   ) u_osc_lo (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_osc_lo),
      .wr_data(REG_WDATA),
      .value(osc_lo_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_OUT_DRV_CTRL),
      .STORE_MASK(MASK_OUT_DRV_CTRL)
   ) u_drv_ctrl (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_drv_ctrl),
      .wr_data(REG_WDATA),
      .value(drv_ctrl_byte)
   );
   // Reserved bits of the divider upper byte are stored, so it keeps all eight
   cfg_byte_reg #(
      .RESET_VAL(RST_OUT_DIV_HI),
      .STORE_MASK(MASK_FULL)
   ) u_div_hi (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_div_hi),
      .wr_data(REG_WDATA),
      .value(div_hi_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_OUT_DIV_LO),
      .STORE_MASK(MASK_FULL)
   ) u_div_lo (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_div_lo),
      .wr_data(REG_WDATA),
      .value(div_lo_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_PLL_INT_HI),
      .STORE_MASK(MASK_PLL_INT_HI)
   ) u_nint_hi (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_nint_hi),
      .wr_data(REG_WDATA),
      .value(nint_hi_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_PLL_INT_LO),
      .STORE_MASK(MASK_FULL)
   ) u_nint_lo (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_nint_lo),
      .wr_data(REG_WDATA),
      .value(nint_lo_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_FRAC),
      .STORE_MASK(MASK_FRAC_B2)
   ) u_num_b2 (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_num_b2),
      .wr_data(REG_WDATA),
      .value(num_b2_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_FRAC),
      .STORE_MASK(MASK_FULL)
   ) u_num_b1 (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_num_b1),
      .wr_data(REG_WDATA),
      .value(num_b1_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_FRAC),
      .STORE_MASK(MASK_FULL)
   ) u_num_b0 (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_num_b0),
      .wr_data(REG_WDATA),
      .value(num_b0_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_FRAC),
      .STORE_MASK(MASK_FRAC_B2)
   ) u_den_b2 (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_den_b2),
      .wr_data(REG_WDATA),
      .value(den_b2_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_FRAC),
      .STORE_MASK(MASK_FULL)
   ) u_den_b1 (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_den_b1),
      .wr_data(REG_WDATA),
      .value(den_b1_byte)
   );
   cfg_byte_reg #(
      .RESET_VAL(RST_FRAC),
      .STORE_MASK(MASK_FULL)
   ) u_den_b0 (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .wr_en(REG_WR && sel_den_b0),
      .wr_data(REG_WDATA),
      .value(den_b0_byte)
   );

   // Read mux; unmapped offsets read zero and drop the hit flag
   always_comb begin
      rdata_d = UNMAPPED_RDATA;
      hit_d = 1'b1;
      case (REG_ADDR)
         OFS_OSC_MARGIN_HI: rdata_d = osc_hi_byte;
         OFS_OSC_MARGIN_LO: rdata_d = osc_lo_byte;
         OFS_OUT_DRV_CTRL: rdata_d = drv_ctrl_byte;
         OFS_OUT_DIV_HI: rdata_d = div_hi_byte;
         OFS_OUT_DIV_LO: rdata_d = div_lo_byte;
         OFS_PLL_INT_HI: rdata_d = nint_hi_byte;
         OFS_PLL_INT_LO: rdata_d = nint_lo_byte;
         OFS_FRAC_NUM_B2: rdata_d = num_b2_byte;
         OFS_FRAC_NUM_B1: rdata_d = num_b1_byte;
         OFS_FRAC_NUM_B0: rdata_d = num_b0_byte;
         OFS_FRAC_DEN_B2: rdata_d = den_b2_byte;
         OFS_FRAC_DEN_B1: rdata_d = den_b1_byte;
         OFS_FRAC_DEN_B0: rdata_d = den_b0_byte;
         default: hit_d = 1'b0;
      endcase
   end

   // Read data registered so the port output comes from a flop
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_q <= RST_RDATA;
      end else if (REG_RD) begin
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign REG_HIT = hit_d;

   // Field assembly
   assign OSC_MARGIN_OFFSET = {osc_lo_byte, osc_hi_byte[OSC_MARGIN_HI_W-1:0]};
   assign DIFF_BUFFER_POWERDOWN = drv_ctrl_byte[DRV_PD_BIT];
   assign OUT_FORMAT = drv_ctrl_byte[FMT_LSB +: FMT_W];
   assign OUT_DIVIDER = {div_hi_byte[OUT_DIV_HI_W-1:0], div_lo_byte};
   // Flags reserved values 0 to 4; the value is still passed through unaltered,
   // since blocking it here would hide a software fault from the divider's user
   assign OUT_DIVIDER_VALID = (OUT_DIVIDER >= OUT_DIV_MIN);
   assign PLL_INT_N_DIVIDER = {nint_hi_byte[PLL_INT_HI_W-1:0], nint_lo_byte};
   assign PLL_FRAC_NUMERATOR = {num_b2_byte[FRAC_HI_W-1:0], num_b1_byte, num_b0_byte};
   assign PLL_FRAC_DENOMINATOR = {den_b2_byte[FRAC_HI_W-1:0], den_b1_byte, den_b0_byte};
endmodule // synth_config_registers

//--- inc/synth_cfg_pkg.sv
// Register map, field layouts and reset values of the synthesizer configuration bank.
// Assumes an 8-bit register port clocked by CLK_SYS, as used by the device's serial front end.
package synth_cfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [7:0] OFS_OSC_MARGIN_HI = 8'h10;
   localparam logic [7:0] OFS_OSC_MARGIN_LO = 8'h11;
   localparam logic [7:0] OFS_OUT_DRV_CTRL = 8'h15;
   localparam logic [7:0] OFS_OUT_DIV_HI = 8'h16;
   localparam logic [7:0] OFS_OUT_DIV_LO = 8'h17;
   localparam logic [7:0] OFS_PLL_INT_HI = 8'h19;
   localparam logic [7:0] OFS_PLL_INT_LO = 8'h1A;
   localparam logic [7:0] OFS_FRAC_NUM_B2 = 8'h1B;
   localparam logic [7:0] OFS_FRAC_NUM_B1 = 8'h1C;
   localparam logic [7:0] OFS_FRAC_NUM_B0 = 8'h1D;
   localparam logic [7:0] OFS_FRAC_DEN_B2 = 8'h1E;
   localparam logic [7:0] OFS_FRAC_DEN_B1 = 8'h1F;
   localparam logic [7:0] OFS_FRAC_DEN_B0 = 8'h20;
   // Stored-bit masks per register
   localparam logic [7:0] MASK_OSC_MARGIN_HI = 8'h03;
   localparam logic [7:0] MASK_OUT_DRV_CTRL = 8'h83;
   localparam logic [7:0] MASK_PLL_INT_HI = 8'h0F;
   localparam logic [7:0] MASK_FRAC_B2 = 8'h3F;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   // Field positions
   localparam int DRV_PD_BIT = 7;
   localparam int FMT_LSB = 0;
   localparam int FMT_W = 2;
   // Value bits held in the HI or B2 byte of each split field
   localparam int OSC_MARGIN_HI_W = 2;
   localparam int OUT_DIV_HI_W = 1;
   localparam int PLL_INT_HI_W = 4;
   localparam int FRAC_HI_W = 6;
   // Reset values
   localparam logic [7:0] RST_OSC_MARGIN_HI = 8'h00;
   localparam logic [7:0] RST_OSC_MARGIN_LO = 8'h80;
   localparam logic [7:0] RST_OUT_DRV_CTRL = 8'h01;
   localparam logic [7:0] RST_OUT_DIV_HI = 8'h00;
   localparam logic [7:0] RST_OUT_DIV_LO = 8'h20;
   localparam logic [7:0] RST_PLL_INT_HI = 8'h00;
   localparam logic [7:0] RST_PLL_INT_LO = 8'h32;
   localparam logic [7:0] RST_FRAC = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;
   // Read value of unmapped offsets
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
   // Output divider legal range
   localparam logic [8:0] OUT_DIV_MIN = 9'h005;
   // Output format codes
   typedef enum logic [1:0] {
      FMT_TRISTATE = 2'h0,
      FMT_LVPECL = 2'h1,
      FMT_LVDS = 2'h2,
      FMT_HCSL = 2'h3
   } out_format_t;
endpackage

//--- rtl/cfg_byte_reg.sv
// One byte-wide configuration register with a mask of stored bits.
// Assumes a write strobe from the same clock domain.
module cfg_byte_reg
   import synth_cfg_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] STORE_MASK = 8'hFF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Write side
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // Stored value, unstored bits read zero
   output logic [7:0] value
);
   logic [7:0] value_q;

   // Unstored bits never load, so writes leave them at zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         value_q <= RESET_VAL & STORE_MASK;
      end else if (wr_en) begin
         value_q <= wr_data & STORE_MASK;
      end
   end

   assign value = value_q;
endmodule // cfg_byte_reg

//--- bench/synth_cfg_chk_sva.sv
// Concurrent checks on the ports of the configuration register bank.
// Assumes one clock domain and byte writes taken at rising CLK_SYS.
module synth_cfg_chk (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // Register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_HIT,
   // Decoded fields
   input wire logic [9:0] OSC_MARGIN_OFFSET,
   input wire logic DIFF_BUFFER_POWERDOWN,
   input wire logic [1:0] OUT_FORMAT,
   input wire logic [8:0] OUT_DIVIDER,
   input wire logic OUT_DIVIDER_VALID,
   input wire logic [11:0] PLL_INT_N_DIVIDER,
   input wire logic [21:0] PLL_FRAC_NUMERATOR,
   input wire logic [21:0] PLL_FRAC_DENOMINATOR
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   a_margin_lo: assert property (REG_WR && REG_ADDR == 8'h11
      |=> OSC_MARGIN_OFFSET[9:2] == $past(REG_WDATA)) else $error("margin upper bits");
   a_margin_hi: assert property (REG_WR && REG_ADDR == 8'h10
      |=> OSC_MARGIN_OFFSET[1:0] == $past(REG_WDATA[1:0])) else $error("margin low bits");
   a_drv_ctrl: assert property (REG_WR && REG_ADDR == 8'h15
      |=> {DIFF_BUFFER_POWERDOWN, OUT_FORMAT} == $past({REG_WDATA[7], REG_WDATA[1:0]}))
      else $error("driver control");
   a_div_lo: assert property (REG_WR && REG_ADDR == 8'h17
      |=> OUT_DIVIDER[7:0] == $past(REG_WDATA)) else $error("divider low byte");
   a_div_hi: assert property (REG_WR && REG_ADDR == 8'h16
      |=> OUT_DIVIDER[8] == $past(REG_WDATA[0])) else $error("divider top bit");
   a_div_valid: assert property (OUT_DIVIDER_VALID == (OUT_DIVIDER >= 9'h005))
      else $error("divider valid flag");
   a_ndiv_hi: assert property (REG_WR && REG_ADDR == 8'h19
      |=> PLL_INT_N_DIVIDER[11:8] == $past(REG_WDATA[3:0])) else $error("N upper bits");
   a_num_top: assert property (REG_WR && REG_ADDR == 8'h1B
      |=> PLL_FRAC_NUMERATOR[21:16] == $past(REG_WDATA[5:0])) else $error("numerator top");
   a_den_top: assert property (REG_WR && REG_ADDR == 8'h1E
      |=> PLL_FRAC_DENOMINATOR[21:16] == $past(REG_WDATA[5:0])) else $error("denominator top");
   a_den_low: assert property (REG_WR && REG_ADDR == 8'h20
      |=> PLL_FRAC_DENOMINATOR[7:0] == $past(REG_WDATA)) else $error("denominator low");
   a_unmapped_rd: assert property (REG_RD && !REG_HIT
      |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule // synth_cfg_chk

bind synth_config_registers synth_cfg_chk i_chk (.CLK_SYS, .ARST_N, .REG_WR, .REG_RD, .REG_HIT,
   .REG_ADDR, .REG_WDATA, .REG_RDATA, .DIFF_BUFFER_POWERDOWN, .OUT_DIVIDER_VALID,
   .OSC_MARGIN_OFFSET, .OUT_FORMAT, .OUT_DIVIDER, .PLL_INT_N_DIVIDER, .PLL_FRAC_NUMERATOR,
   .PLL_FRAC_DENOMINATOR);

//--- bench/synth_config_registers_tb.sv
// Self-checking bench for the configuration register bank.
// Assumes the bank alone, inputs driven at falling edges of a 40 MHz clock.
module synth_config_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, hit, pd, dvalid;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [9:0] ofs;
   logic [1:0] fmt;
   logic [8:0] div;
   logic [11:0] ndiv;
   logic [21:0] num, den;
   int err_total = 0, checks = 0, cyc = 0;
   always #12.5 clk_sys = ~clk_sys;
   synth_config_registers i_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit),
      .OSC_MARGIN_OFFSET(ofs), .DIFF_BUFFER_POWERDOWN(pd), .OUT_FORMAT(fmt), .OUT_DIVIDER(div),
      .OUT_DIVIDER_VALID(dvalid), .PLL_INT_N_DIVIDER(ndiv), .PLL_FRAC_NUMERATOR(num),
      .PLL_FRAC_DENOMINATOR(den));
   task automatic chk(input logic [21:0] got, exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys) {reg_wr, addr, wdata} = {1'b1, a, d};
      @(negedge clk_sys) reg_wr = 0;
   endtask
   // Sample one full cycle after the strobe so either capture edge is covered
   task automatic rd(input logic [7:0] a, exp);
      @(negedge clk_sys) {reg_rd, addr} = {1'b1, a};
      @(negedge clk_sys) reg_rd = 0;
      @(negedge clk_sys) chk(rdata, exp);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict;
      end
   end
   task automatic test_reset;
      chk(ofs, 10'h200);
      chk({pd, fmt}, 3'h1);
      chk({div, ndiv}, 21'h020032);
      chk(num | den, 22'h0);
      rd(8'h11, 8'h80);
      chk(hit, 1'b1);
      $display("reset values done");
   endtask
   // Reserved control bits are written high and must read back low
   task automatic test_format_margin;
      for (int f = 0; f < 4; f++) begin
         wr(8'h15, 8'hFC | f[7:0]);
         chk({pd, fmt}, {1'b1, f[1:0]});
         rd(8'h15, 8'h80 | f[7:0]);
      end
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h03);
      chk(ofs, 10'h203);
      $display("format and margin done");
   endtask
   // Reserved value 4 stays stored but drops the valid flag
   task automatic test_divider;
      wr(8'h16, 8'hFF);
      rd(8'h16, 8'hFF);
      wr(8'h17, 8'h04);
      chk({dvalid, div}, 10'h304);
      wr(8'h16, 8'h00);
      chk({dvalid, div}, 10'h004);
      wr(8'h17, 8'h05);
      chk({dvalid, div}, 10'h205);
      wr(8'h16, 8'h01);
      wr(8'h17, 8'hFF);
      chk({dvalid, div}, 10'h3FF);
      $display("divider done");
   endtask
   task automatic test_pll_unmapped;
      wr(8'h19, 8'hFA);
      wr(8'h1A, 8'hBC);
      chk(ndiv, 12'hABC);
      wr(8'h1B, 8'hFF);
      wr(8'h1C, 8'h12);
      wr(8'h1D, 8'h34);
      chk(num, 22'h3F1234);
      wr(8'h1E, 8'hC1);
      wr(8'h1F, 8'h56);
      wr(8'h20, 8'h78);
      chk(den, 22'h015678);
      rd(8'h1E, 8'h01);
      wr(8'h12, 8'hFF);
      rd(8'h12, 8'h00);
      chk(hit, 1'b0);
      $display("pll and unmapped done");
   endtask
   // Mid-run reset over written values, reserved divider bits included
   task automatic test_reset_again;
      wr(8'h16, 8'hFE);
      @(negedge clk_sys) arst_n = 0;
      @(negedge clk_sys) chk(ofs, 10'h200);
      chk({pd, fmt}, 3'h1);
      chk({div, ndiv}, 21'h020032);
      chk(num | den, 22'h0);
      arst_n = 1;
      rd(8'h16, 8'h00);
      $display("second reset done");
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      arst_n = 1;
      test_reset;
      test_format_margin;
      test_divider;
      test_pll_unmapped;
      test_reset_again;
      print_verdict;
   end
endmodule // synth_config_registers_tb
